//--- bench/power_down_mode_control_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module power_down_mode_control_bench;
  import power_down_pkg::*;
  localparam int LIMIT = 64;
  // ==========================================================
  // Signals
  logic            core_clk = 1'b0;
  logic            resetn = 1'b0;
  logic [3:0]      awAddr = 4'h0;
  logic            awValid = 1'b0;
  logic [31:0]     wData = 32'h0;
  logic [3:0]      wStrb = 4'hF;
  logic            wValid = 1'b0;
  logic            bReady = 1'b0;
  logic [3:0]      arAddr = 4'h0;
  logic            arValid = 1'b0;
  logic            rReady = 1'b0;
  logic            sleepExec = 1'b0;
  logic            manualN = 1'b1;
  logic            wdPor = 1'b0;
  logic            wdMr = 1'b0;
  logic            emuSel = 1'b0;
  logic            pauseBus = 1'b0;
  logic            porReq = 1'b0;
  logic            nmiLevel = 1'b0;
  logic            awReady, wReady, bValid, arReady, rValid;
  logic [1:0]      bResp, rResp;
  logic [31:0]     rData;
  logic            busCycleEnd, porN, nmiPin;
  module_stop_type stop;
  logic            cpuHalt, cpuReset, cpuManualReset, perStop, oscStop;
  logic            wdOnly, portFloat, nmiStart, sleepActive;
  int              error_cnt = 0;
  int              checks_done = 0;

  always #12.5 core_clk = ~core_clk;

  // ==========================================================
  // Instances
  power_pin_partner i_partner (.core_clk(core_clk), .resetn(resetn), .pauseBus(pauseBus),
    .porReq(porReq), .nmiLevel(nmiLevel), .busCycleEnd(busCycleEnd),
    .power_on_reset_pin_n(porN), .nmiPin(nmiPin));

  power_down_mode_control #(.SETTLE_LIMIT(LIMIT)) i_dut (.core_clk(core_clk),
    .resetn(resetn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sleepExec(sleepExec), .busCycleEnd(busCycleEnd), .power_on_reset_pin_n(porN),
    .manual_reset_pin_n(manualN), .watchdogPowerOnReset(wdPor),
    .watchdogManualReset(wdMr), .nmiPin(nmiPin), .emulator_select_pin(emuSel),
    .moduleStop(stop), .cpuHalt(cpuHalt), .cpuReset(cpuReset),
    .cpuManualReset(cpuManualReset), .peripheralClockStop(perStop),
    .oscillatorStop(oscStop), .watchdogClockOnly(wdOnly), .portFloat(portFloat),
    .nmiExceptionStart(nmiStart), .sleepActive(sleepActive));

  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge core_clk);
      if (awValid && awReady === 1'b1)
      begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady === 1'b1)
      begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bValid !== 1'b1);
    bReady <= 1'b0;
    `CHK(bResp, r)
    tick(1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge core_clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    do @(posedge core_clk); while (rValid !== 1'b1);
    rReady <= 1'b0;
    `CHK(rData, d)
    `CHK(rResp, r)
    tick(1);
  endtask

  task automatic sleepPulse;
    sleepExec <= 1'b1;
    tick(1);
    sleepExec <= 1'b0;
    tick(4);
  endtask

  task automatic standby(input logic e, input logic f, input logic usePor);
    int n;
    nmiLevel <= ~e;
    wr(WAKE_CTL_ADDR, {24'h0, 4'h7, 3'h0, e}, RESP_OKAY);
    wr(STANDBY_CTL_ADDR, {24'h0, 1'b1, f, 6'h0}, RESP_OKAY);
    sleepPulse();
    `CHK(oscStop, 1'b1)
    `CHK(perStop, 1'b1)
    `CHK(cpuHalt, 1'b1)
    `CHK(portFloat, f)
    if (usePor)
    begin
      porReq <= 1'b1;
      tick(1);
      porReq <= 1'b0;
      tick(3);
      `CHK(oscStop, 1'b0)
      `CHK(perStop, 1'b0)
      `CHK(cpuReset, 1'b1)
      tick(30);
      `CHK(cpuReset, 1'b0)
    end
    else
    begin
      nmiLevel <= e;
      n = 0;
      tick(4);
      `CHK(wdOnly, 1'b1)
      `CHK(perStop, 1'b1)
      while (nmiStart !== 1'b1 && n < 200)
      begin
        tick(1);
        n++;
      end
      `CHK((n + 4 >= LIMIT) && (n + 4 <= LIMIT + 10), 1'b1)
      tick(2);
      `CHK(perStop, 1'b0)
      `CHK(cpuHalt, 1'b0)
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    tick(12);
    resetn <= 1'b1;
    tick(1);
    rd(MSTCR_TWO_ADDR, 32'h0000F0F0, RESP_OKAY);
    `CHK(stop, 7'h78)
    pauseBus <= 1'b1;
    wr(MSTCR_TWO_ADDR, 32'h0000FFFF, RESP_OKAY);
    tick(6);
    `CHK(stop, 7'h78)
    pauseBus <= 1'b0;
    tick(12);
    `CHK(stop, 7'h7F)
    rd(MSTCR_TWO_ADDR, 32'h0000F0FD, RESP_OKAY);
    emuSel <= 1'b1;
    tick(12);
    `CHK(stop, 7'h79)
    emuSel <= 1'b0;
    wr(MSTCR_TWO_ADDR, 32'h0000C0C0, RESP_OKAY);
    tick(12);
    `CHK(stop, 7'h00)
    wStrb <= 4'h1;
    wr(MSTCR_TWO_ADDR, 32'h0000FFFF, RESP_OKAY);
    rd(MSTCR_TWO_ADDR, 32'h0000C0FD, RESP_OKAY);
    wStrb <= 4'hF;
    wr(MSTCR_TWO_ADDR, 32'h0000C0C0, RESP_OKAY);
    wr(4'h2, 32'h0000FFFF, RESP_SLVERR);
    rd(4'h2, 32'h0, RESP_SLVERR);
    rd(MSTCR_TWO_ADDR, 32'h0000C0C0, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(STANDBY_CTL_ADDR, 32'h0, RESP_OKAY);
      sleepPulse();
      `CHK(cpuHalt, 1'b1)
      `CHK(sleepActive, 1'b1)
      `CHK(perStop, 1'b0)
      `CHK(oscStop, 1'b0)
      case (i)
        0: porReq <= 1'b1;
        1: manualN <= 1'b0;
        2: wdPor <= 1'b1;
        default: wdMr <= 1'b1;
      endcase
      tick(4);
      `CHK(sleepActive, 1'b0)
      `CHK(cpuHalt, 1'b0)
      if (i == 1)
        `CHK(cpuManualReset, 1'b1)
      porReq <= 1'b0;
      manualN <= 1'b1;
      wdPor <= 1'b0;
      wdMr <= 1'b0;
      tick(30);
    end
    standby(1'b1, 1'b1, 1'b0);
    standby(1'b0, 1'b0, 1'b0);
    standby(1'b1, 1'b0, 1'b1);
    rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    tally_and_finish();
  end

  initial
  begin
    #(25 * 20000);
    error_cnt++;
    tally_and_finish();
  end
endmodule

//--- bench/power_pin_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Pin and bus-cycle partner
module power_pin_partner
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic pauseBus,
  input  wire logic porReq,
  input  wire logic nmiLevel,
  output logic      busCycleEnd,
  output logic      power_on_reset_pin_n,
  output logic      nmiPin
);
  logic [2:0] phase_q;
  logic [4:0] hold_q;

  // Interrupt pin level set by software timing
  assign nmiPin = nmiLevel;
  // Reset pin held low for a settling span
  assign power_on_reset_pin_n = (hold_q == 5'h00);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q <= 3'h0;
      hold_q <= 5'h00;
      busCycleEnd <= 1'b0;
    end
    else
    begin
      phase_q <= phase_q + 3'h1;
      busCycleEnd <= !pauseBus && (phase_q == 3'h7);
      if (porReq)
        hold_q <= 5'h14;
      else if (hold_q != 5'h00)
        hold_q <= hold_q - 5'h01;
    end
  end
endmodule

//--- hdl/power_down_mode_control.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Contract
// - Writable standby bit at 1 stops its peripheral; at 0 releases it.
// - Peripheral stop or resume takes effect at end of current bus cycle.
// - Bit 13 gates multi-function timer, resets to 1.
// - Bit 12 gates compare match timer, resets to 1.
// - Bit 0 gates break controller, resets to 0.
// - Bits 2, 3 gate debug units, reset 0, ignored while emulator pin high.
// - Reserved bits read fixed values; software writes those back.
// - Sleep instruction with standby select 0 enters sleep, CPU halts.
// - In sleep, all peripherals besides the CPU keep running.
// - Power-on reset pin low ends sleep and resets CPU until release.
// - Watchdog power-on reset also ends sleep.
// - Manual reset pin low with power-on pin high ends sleep.
// - Watchdog manual reset also ends sleep.
// - Sleep instruction with standby select 1 stops CPU, peripherals, oscillator.
// - CPU registers and RAM keep contents throughout standby.
// - Port float bit picks hold or high impedance pins in standby.
// - Selected interrupt edge in standby restarts oscillator feeding watchdog only.
// - Watchdog overflow restores chip clock, leaves standby, starts interrupt handling.
// - Power-on pin low in standby restarts oscillator and whole chip clock.
module power_down_mode_control
#(
  parameter int SETTLE_LIMIT = 65536
)
(
  input  wire logic                           core_clk,
  input  wire logic                           resetn,
  input  wire logic [3:0]                     s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [3:0]                     s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic                           sleepExec,
  input  wire logic                           busCycleEnd,
  input  wire logic                           power_on_reset_pin_n,
  input  wire logic                           manual_reset_pin_n,
  input  wire logic                           watchdogPowerOnReset,
  input  wire logic                           watchdogManualReset,
  input  wire logic                           nmiPin,
  input  wire logic                           emulator_select_pin,
  output power_down_pkg::module_stop_type     moduleStop,
  output logic                                cpuHalt,
  output logic                                cpuReset,
  output logic                                cpuManualReset,
  output logic                                peripheralClockStop,
  output logic                                oscillatorStop,
  output logic                                watchdogClockOnly,
  output logic                                portFloat,
  output logic                                nmiExceptionStart,
  output logic                                sleepActive
);
  import power_down_pkg::*;

  if (SETTLE_LIMIT < 16 || SETTLE_LIMIT > 32'h00FFFFFF)
  begin : g_limit_check
    $error("SETTLE_LIMIT out of range");
  end

  // ==========================================================
  // Bus slave
  logic                     awHeld_q;
  logic                     wHeld_q;
  logic [3:0]               awAddr_q;
  logic [31:0]              wData_q;
  logic [3:0]               wStrb_q;
  logic [15:0]              mstcr_q;
  logic [1:0]               standbyCtl_q;
  logic                     nmiEdge_q;
  logic [WDT_CKS_WIDTH-1:0] wdtCks_q;
  power_state_type          state_q;
  logic [23:0]              settleCount_q;
  logic                     nmiPrev_q;

  wire       writeFire  = awHeld_q && wHeld_q && !s_axi_bvalid;
  wire       hitMstcr   = awAddr_q == MSTCR_TWO_ADDR;
  wire       hitStbyCtl = awAddr_q == STANDBY_CTL_ADDR;
  wire       hitWake    = awAddr_q == WAKE_CTL_ADDR;
  wire       writeOk    = hitMstcr || hitStbyCtl || hitWake || awAddr_q == STATUS_ADDR;
  wire       lowLane    = wStrb_q[0];
  wire       highLane   = wStrb_q[1];
  wire [15:0] laneMask  = {{8{highLane}}, {8{lowLane}}};
  wire [15:0] mstcrNext = (mstcr_q & ~(laneMask & MSTCR_WRITABLE))
                        | (wData_q[15:0] & laneMask & MSTCR_WRITABLE);
  wire       readMapped = s_axi_araddr inside {MSTCR_TWO_ADDR, STANDBY_CTL_ADDR,
                                              WAKE_CTL_ADDR, STATUS_ADDR};
  wire [31:0] readData  =
      (s_axi_araddr == MSTCR_TWO_ADDR)   ? {16'h0000, mstcr_q | MSTCR_FIXED_ONE} :
      (s_axi_araddr == STANDBY_CTL_ADDR) ? {24'h000000, standbyCtl_q, 6'h00} :
      (s_axi_araddr == WAKE_CTL_ADDR)    ? {24'h000000, 1'b0, wdtCks_q, 3'h0, nmiEdge_q} :
      (s_axi_araddr == STATUS_ADDR)      ? {30'h00000000, state_q} : 32'h00000000;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      else if (writeFire)
        awHeld_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      else if (writeFire)
        wHeld_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end
    else
    begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready);
      if (writeFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeOk ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readData;
        s_axi_rresp  <= readMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mstcr_q      <= MSTCR_RESET;
      standbyCtl_q <= 2'b00;
      nmiEdge_q    <= 1'b0;
      wdtCks_q     <= '0;
    end
    else if (writeFire)
    begin
      if (hitMstcr)
        mstcr_q <= mstcrNext;
      if (hitStbyCtl && lowLane)
        standbyCtl_q <= wData_q[STANDBY_SEL_BIT:PORT_FLOAT_BIT];
      if (hitWake && lowLane)
      begin
        nmiEdge_q <= wData_q[NMI_EDGE_BIT];
        wdtCks_q  <= wData_q[WDT_CKS_LSB +: WDT_CKS_WIDTH];
      end
    end
  end

  // ==========================================================
  // Peripheral stop, applied at bus cycle end
  wire debugIgnored = emulator_select_pin;
  wire [6:0] stopNext = {mstcr_q[MULTI_TIMER_BIT], mstcr_q[COMPARE_TIMER_BIT],
                         mstcr_q[CONV_ONE_BIT], mstcr_q[CONV_ZERO_BIT],
                         mstcr_q[TRACE_DBG_BIT] && !debugIgnored,
                         mstcr_q[DEBUG_IF_BIT] && !debugIgnored,
                         mstcr_q[BREAK_CTL_BIT]};

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      moduleStop <= module_stop_type'(7'h78);
    else if (busCycleEnd)
      moduleStop <= module_stop_type'(stopNext);
  end

  // ==========================================================
  // Power state machine
  wire resetEvent   = !power_on_reset_pin_n || watchdogPowerOnReset;
  wire manualEvent  = (power_on_reset_pin_n && !manual_reset_pin_n) || watchdogManualReset;
  wire nmiRise      = nmiPin && !nmiPrev_q;
  wire nmiFall      = !nmiPin && nmiPrev_q;
  wire wakeEdge     = nmiEdge_q ? nmiRise : nmiFall;
  wire [23:0] settleTarget = 24'(SETTLE_LIMIT >> (SETTLE_BASE * (7 - wdtCks_q)));
  wire settleDone   = settleCount_q >= settleTarget;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q       <= RUN_STATE;
      settleCount_q <= 24'h000000;
      nmiPrev_q     <= 1'b0;
    end
    else
    begin
      nmiPrev_q <= nmiPin;
      unique case (state_q)
        RUN_STATE:
          if (sleepExec && !resetEvent && !manualEvent)
            state_q <= standbyCtl_q[1] ? STANDBY_STATE : SLEEP_STATE;
        SLEEP_STATE:
          if (resetEvent || manualEvent)
            state_q <= RUN_STATE;
        STANDBY_STATE:
          if (!power_on_reset_pin_n)
            state_q <= RUN_STATE;
          else if (wakeEdge)
          begin
            state_q       <= SETTLE_STATE;
            settleCount_q <= 24'h000000;
          end
        SETTLE_STATE:
          if (!power_on_reset_pin_n || settleDone)
            state_q <= RUN_STATE;
          else
            settleCount_q <= settleCount_q + 24'h000001;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  wire inStandby = state_q == STANDBY_STATE || state_q == SETTLE_STATE;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpuHalt             <= 1'b0;
      cpuReset            <= 1'b0;
      cpuManualReset      <= 1'b0;
      peripheralClockStop <= 1'b0;
      oscillatorStop      <= 1'b0;
      watchdogClockOnly   <= 1'b0;
      portFloat           <= 1'b0;
      nmiExceptionStart   <= 1'b0;
      sleepActive         <= 1'b0;
    end
    else
    begin
      cpuHalt             <= state_q != RUN_STATE;
      cpuReset            <= resetEvent;
      cpuManualReset      <= manualEvent && !resetEvent;
      peripheralClockStop <= inStandby;
      oscillatorStop      <= state_q == STANDBY_STATE;
      watchdogClockOnly   <= state_q == SETTLE_STATE;
      portFloat           <= inStandby && standbyCtl_q[0];
      nmiExceptionStart   <= state_q == SETTLE_STATE && settleDone
                             && power_on_reset_pin_n;
      sleepActive         <= state_q == SLEEP_STATE;
    end
  end

  // ==========================================================
  // Checks
  a_sleep_entry: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == RUN_STATE && sleepExec && !resetEvent && !manualEvent && !standbyCtl_q[1]
    |=> state_q == SLEEP_STATE)
    else $error("sleep not entered");
  a_standby_entry: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == RUN_STATE && sleepExec && !resetEvent && !manualEvent && standbyCtl_q[1]
    |=> state_q == STANDBY_STATE ##1 oscillatorStop && peripheralClockStop)
    else $error("standby not entered");
  a_sleep_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == SLEEP_STATE && resetEvent |=> state_q == RUN_STATE ##0 cpuReset)
    else $error("reset did not end sleep");
  a_sleep_manual: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == SLEEP_STATE && manualEvent && !resetEvent |=> state_q == RUN_STATE)
    else $error("manual reset did not end sleep");
  a_wake_edge: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == STANDBY_STATE && power_on_reset_pin_n && wakeEdge
    |=> state_q == SETTLE_STATE ##1 watchdogClockOnly)
    else $error("edge wake missed");
  a_settle_exit: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == SETTLE_STATE && settleDone && power_on_reset_pin_n
    |=> state_q == RUN_STATE && nmiExceptionStart)
    else $error("overflow did not wake");
  a_standby_reset: assert property (@(posedge core_clk) disable iff (!resetn)
    inStandby && !power_on_reset_pin_n |=> state_q == RUN_STATE)
    else $error("reset pin did not wake");
  a_debug_ignore: assert property (@(posedge core_clk) disable iff (!resetn)
    busCycleEnd && emulator_select_pin |=> !moduleStop.traceDebugger && !moduleStop.debugInterface)
    else $error("debug gated under emulator");
  a_stop_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    !busCycleEnd |=> $stable(moduleStop))
    else $error("stop changed mid cycle");
  a_float_pins: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == RUN_STATE |=> !portFloat)
    else $error("pins float while running");
  a_reset_follow: assert property (@(posedge core_clk) disable iff (!resetn)
    resetEvent |=> cpuReset)
    else $error("reset not passed to cpu");
  a_manual_follow: assert property (@(posedge core_clk) disable iff (!resetn)
    manualEvent && !resetEvent |=> cpuManualReset && !cpuReset)
    else $error("manual reset not passed to cpu");
  a_sleep_runs: assert property (@(posedge core_clk) disable iff (!resetn)
    state_q == SLEEP_STATE |=> cpuHalt && !peripheralClockStop && !oscillatorStop)
    else $error("peripherals stopped in sleep");

endmodule

//--- hdl/power_down_pkg.sv
package power_down_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] MSTCR_TWO_ADDR   = 4'h0;
  localparam logic [3:0] STANDBY_CTL_ADDR = 4'h4;
  localparam logic [3:0] WAKE_CTL_ADDR    = 4'h8;
  localparam logic [3:0] STATUS_ADDR      = 4'hC;

  // ==========================================================
  // Module standby register fields
  localparam int MULTI_TIMER_BIT   = 13;
  localparam int COMPARE_TIMER_BIT = 12;
  localparam int CONV_ONE_BIT      = 5;
  localparam int CONV_ZERO_BIT     = 4;
  localparam int TRACE_DBG_BIT     = 3;
  localparam int DEBUG_IF_BIT      = 2;
  localparam int BREAK_CTL_BIT     = 0;
  localparam logic [15:0] MSTCR_WRITABLE = 16'h303D;
  localparam logic [15:0] MSTCR_FIXED_ONE = 16'hC0C0;
  localparam logic [15:0] MSTCR_RESET     = 16'hF0F0;

  // ==========================================================
  // Standby control and wake control fields
  localparam int STANDBY_SEL_BIT = 7;
  localparam int PORT_FLOAT_BIT  = 6;
  localparam int NMI_EDGE_BIT    = 0;
  localparam int WDT_CKS_LSB     = 4;
  localparam int WDT_CKS_WIDTH   = 3;
  localparam int SETTLE_BASE     = 2;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RUN_STATE,
    SLEEP_STATE,
    STANDBY_STATE,
    SETTLE_STATE
  } power_state_type;

  typedef struct packed {
    logic multiTimer;
    logic compareTimer;
    logic converterOne;
    logic converterZero;
    logic traceDebugger;
    logic debugInterface;
    logic breakController;
  } module_stop_type;

endpackage
